//--- include/mbs_defines.vh
// Constants shared by the mapping server and its assertion checker.
`ifndef MBS_DEFINES_VH
`define MBS_DEFINES_VH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define MBS_PROTO_ID      16'h0000
`define MBS_REQ_BYTES     9'h00C
`define MBS_MIN_BYTES     9'h008
`define MBS_HDR_BYTES     9'h006
`define MBS_ECHO_LEN      16'h0006
`define MBS_EXC_LEN       16'h0003
`define MBS_RD_LEN_BASE   16'h0003
`define MBS_RD_DATA_IDX   9'h009
`define MBS_EXC_TX_BYTES  9'h009

// ----------------------------------------------------------------------
// Function and exception codes
// ----------------------------------------------------------------------
`define MBS_FC_READ       8'h03
`define MBS_FC_COIL       8'h05
`define MBS_FC_WRITE      8'h06
`define MBS_EXC_FLAG      8'h80
`define MBS_EXC_FUNC      8'h01
`define MBS_EXC_ADDR      8'h02
`define MBS_EXC_VALUE     8'h03

// ----------------------------------------------------------------------
// Address areas and values
// ----------------------------------------------------------------------
`define MBS_UNIT_MIN      8'h01
`define MBS_UNIT_MAX      8'hF7
`define MBS_WORD_BASE     16'h4E20
`define MBS_WORD_LAST     16'h501C
`define MBS_COIL_BASE     16'h0040
`define MBS_COIL_LAST     16'h007F
`define MBS_COIL_ON       16'hFF00
`define MBS_COIL_OFF      16'h0000
`define MBS_MAX_QTY       16'h007D

`endif

//--- hw/mbs_order_conv.v
// Byte order conversion of one mapping word toward its downstream slave.
`timescale 1ns/1ps
`default_nettype none

module mbs_order_conv (
    input  wire [15:0] word_in,
    input  wire        swap,
    output wire [15:0] word_out
);

    // A 16-bit word is passed bit for bit whatever its signedness; only the
    // byte order set for the slave (AB or BA) changes what goes out.
    assign word_out = swap ? {word_in[7:0], word_in[15:8]} : word_in;

endmodule // mbs_order_conv

`default_nettype wire

//--- hw/mbs_server.v
// Modbus TCP request handler for the boolean and word mapping areas.
`timescale 1ns/1ps
`default_nettype none
`include "mbs_defines.vh"

// Summary of operation
// RULE_01: Frame header: transaction, protocol zero, length, unit.
// RULE_02: Act only on own unit address, echo it.
// RULE_03: Function 05 with FF00 sets coil entry.
// RULE_04: Coil write reply echoes fields, length six.
// RULE_05: Function 03 reads consecutive words from start.
// RULE_06: Byte count twice quantity; length counts payload.
// RULE_07: Word area starts 4E20, ascending, high first.
// RULE_08: Function 06 writes word within 4E20..501C.
// RULE_09: Forward changed values to configured downstream slave.
// RULE_10: Master uses function 15 for multiple coils; the server answers function 15 with exception 01.
// RULE_11: Word converted per slave byte order setting.
// RULE_12: Coil writes only to 0040..007F.
// RULE_13: Coil value 0000 clears the entry.
// RULE_14: Bad address or function gives exception.
module mbs_server (
    input  wire        CLK_SYS,
    input  wire        SRST,
    input  wire [7:0]  UNIT_ADDR,
    input  wire [7:0]  RX_DATA,
    input  wire        RX_VALID,
    input  wire        RX_LAST,
    output reg         RX_READY,
    output reg  [7:0]  TX_DATA,
    output reg         TX_VALID,
    output reg         TX_LAST,
    input  wire        TX_READY,
    input  wire [15:0] SLAVE_PRESENT,
    input  wire [15:0] SLAVE_SWAP,
    output reg         FWD_VALID,
    output reg         FWD_COIL,
    output reg  [3:0]  FWD_SLAVE,
    output reg  [15:0] FWD_ADDR,
    output reg  [15:0] FWD_DATA,
    output reg  [63:0] COIL_STATE
);

    // ------------------------------------------------------------------
    // States and reply kinds
    // ------------------------------------------------------------------
    localparam [1:0] S_RECV = 2'b00;
    localparam [1:0] S_EXEC = 2'b01;
    localparam [1:0] S_SEND = 2'b10;

    localparam [1:0] K_ECHO = 2'b00;
    localparam [1:0] K_READ = 2'b01;
    localparam [1:0] K_EXC  = 2'b10;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function in_word_area;
        input [16:0] a;
        begin
            in_word_area = (a >= {1'b0, `MBS_WORD_BASE}) && (a <= {1'b0, `MBS_WORD_LAST});
        end
    endfunction

    function [8:0] word_offset;
        input [15:0] a;
        reg   [15:0] d;
        begin
            d = a - `MBS_WORD_BASE;
            word_offset = d[8:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg [7:0]  hdr [0:11];
    reg [15:0] word_mem [0:511];

    reg [1:0]  state_r;
    reg [8:0]  rx_cnt_r;
    reg [1:0]  kind_r;
    reg [7:0]  exc_code_r;
    reg [7:0]  byte_cnt_r;
    reg [8:0]  rd_base_r;
    reg [8:0]  tx_idx_r;
    reg [8:0]  tx_len_r;

    wire [15:0] f_tid   = {hdr[0], hdr[1]};
    wire [15:0] f_proto = {hdr[2], hdr[3]};
    wire [15:0] f_len   = {hdr[4], hdr[5]};
    wire [7:0]  f_unit  = hdr[6];
    wire [7:0]  f_func  = hdr[7];
    wire [15:0] f_addr  = {hdr[8], hdr[9]};
    wire [15:0] f_val   = {hdr[10], hdr[11]};

    wire [8:0]  rx_cnt_inc = (rx_cnt_r == 9'h1FF) ? rx_cnt_r : rx_cnt_r + 9'h001;
    wire [8:0]  w_off      = word_offset(f_addr);
    wire [16:0] rd_end     = {1'b0, f_addr} + {1'b0, f_val} - 17'h00001;
    wire [3:0]  word_slave = w_off[8:5];
    wire [3:0]  coil_slave = f_addr[5:2];
    wire [15:0] swapped;

    mbs_order_conv u_conv (
        .word_in  (f_val),
        .swap     (SLAVE_SWAP[word_slave]),
        .word_out (swapped)
    );

    // ------------------------------------------------------------------
    // Request checks
    // ------------------------------------------------------------------
    wire [15:0] cnt_ext  = {7'h00, rx_cnt_r};
    wire        hdr_ok   = (rx_cnt_r >= `MBS_MIN_BYTES) && (f_proto == `MBS_PROTO_ID) &&
                           (f_len == cnt_ext - {7'h00, `MBS_HDR_BYTES}); // see RULE_01
    wire        unit_ok  = (f_unit == UNIT_ADDR) && (UNIT_ADDR >= `MBS_UNIT_MIN) &&
                           (UNIT_ADDR <= `MBS_UNIT_MAX); // see RULE_02
    wire        size_ok  = (rx_cnt_r == `MBS_REQ_BYTES);
    wire        coil_ok  = (f_addr >= `MBS_COIL_BASE) && (f_addr <= `MBS_COIL_LAST); // see RULE_12
    wire        cval_ok  = (f_val == `MBS_COIL_ON) || (f_val == `MBS_COIL_OFF);
    wire        qty_ok   = (f_val != 16'h0000) && (f_val <= `MBS_MAX_QTY);

    reg [1:0]   kind_nxt;
    reg [7:0]   exc_nxt;
    reg         do_coil;
    reg         do_word;

    always @* begin
        kind_nxt = K_EXC;
        exc_nxt  = `MBS_EXC_FUNC;
        do_coil  = 1'b0;
        do_word  = 1'b0;
        case (f_func)
            `MBS_FC_READ: begin
                if (!size_ok || !qty_ok) begin
                    exc_nxt = `MBS_EXC_VALUE;
                end else if (!in_word_area({1'b0, f_addr}) || !in_word_area(rd_end)) begin
                    exc_nxt = `MBS_EXC_ADDR; // see RULE_14
                end else begin
                    kind_nxt = K_READ; // see RULE_05
                end
            end
            `MBS_FC_COIL: begin
                if (!size_ok || !cval_ok) begin
                    exc_nxt = `MBS_EXC_VALUE;
                end else if (!coil_ok) begin
                    exc_nxt = `MBS_EXC_ADDR; // see RULE_14
                end else begin
                    kind_nxt = K_ECHO;
                    do_coil  = 1'b1;
                end
            end
            `MBS_FC_WRITE: begin
                if (!size_ok) begin
                    exc_nxt = `MBS_EXC_VALUE;
                end else if (!in_word_area({1'b0, f_addr})) begin
                    exc_nxt = `MBS_EXC_ADDR; // see RULE_08
                end else begin
                    kind_nxt = K_ECHO;
                    do_word  = 1'b1;
                end
            end
            default: begin
                // Multiple-coil and other functions are not served here.
                exc_nxt = `MBS_EXC_FUNC; // see RULE_14
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Reply byte generation
    // ------------------------------------------------------------------
    wire [8:0]  rel_idx   = tx_idx_r - `MBS_RD_DATA_IDX;
    wire [8:0]  rd_ptr    = rd_base_r + {1'b0, rel_idx[8:1]};
    wire [15:0] rd_word   = word_mem[rd_ptr];
    wire [15:0] proto_w   = `MBS_PROTO_ID;
    wire [15:0] rsp_len   = (kind_r == K_READ) ? `MBS_RD_LEN_BASE + {8'h00, byte_cnt_r} :
                            (kind_r == K_EXC)  ? `MBS_EXC_LEN : `MBS_ECHO_LEN;
    reg  [7:0]  tx_byte;

    always @* begin
        tx_byte = 8'h00;
        case (tx_idx_r)
            9'h000:  tx_byte = f_tid[15:8];
            9'h001:  tx_byte = f_tid[7:0];
            9'h002:  tx_byte = proto_w[15:8]; // see RULE_01
            9'h003:  tx_byte = proto_w[7:0];
            9'h004:  tx_byte = rsp_len[15:8]; // see RULE_06
            9'h005:  tx_byte = rsp_len[7:0];
            9'h006:  tx_byte = f_unit; // see RULE_02
            9'h007:  tx_byte = (kind_r == K_EXC) ? (f_func | `MBS_EXC_FLAG) : f_func;
            9'h008: begin
                if (kind_r == K_READ) begin
                    tx_byte = byte_cnt_r; // see RULE_06
                end else if (kind_r == K_EXC) begin
                    tx_byte = exc_code_r;
                end else begin
                    tx_byte = hdr[8];
                end
            end
            default: begin
                if (kind_r == K_READ) begin
                    tx_byte = rel_idx[0] ? rd_word[7:0] : rd_word[15:8]; // see RULE_07
                end else begin
                    tx_byte = hdr[tx_idx_r[3:0]]; // see RULE_04
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Request capture and word memory
    // ------------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (state_r == S_RECV && RX_READY && RX_VALID && rx_cnt_r < `MBS_REQ_BYTES) begin
            hdr[rx_cnt_r[3:0]] <= RX_DATA; // see RULE_01
        end
        if (state_r == S_EXEC && hdr_ok && unit_ok && do_word) begin
            word_mem[w_off] <= f_val; // see RULE_08
        end
    end

    // ------------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            state_r    <= S_RECV;
            rx_cnt_r   <= 9'h000;
            kind_r     <= K_ECHO;
            exc_code_r <= 8'h00;
            byte_cnt_r <= 8'h00;
            rd_base_r  <= 9'h000;
            tx_idx_r   <= 9'h000;
            tx_len_r   <= 9'h000;
            RX_READY   <= 1'b0;
            TX_DATA    <= 8'h00;
            TX_VALID   <= 1'b0;
            TX_LAST    <= 1'b0;
            FWD_VALID  <= 1'b0;
            FWD_COIL   <= 1'b0;
            FWD_SLAVE  <= 4'h0;
            FWD_ADDR   <= 16'h0000;
            FWD_DATA   <= 16'h0000;
            COIL_STATE <= 64'h0000000000000000;
        end else begin
            FWD_VALID <= 1'b0;
            case (state_r)
                S_RECV: begin
                    RX_READY <= 1'b1;
                    if (RX_READY && RX_VALID) begin
                        rx_cnt_r <= rx_cnt_inc;
                        if (RX_LAST) begin
                            RX_READY <= 1'b0;
                            state_r  <= S_EXEC;
                        end
                    end
                end
                S_EXEC: begin
                    rx_cnt_r <= 9'h000;
                    if (!hdr_ok || !unit_ok) begin
                        // Frames for another unit or with a bad header get no reply.
                        state_r <= S_RECV; // see RULE_02
                    end else begin
                        kind_r     <= kind_nxt;
                        exc_code_r <= exc_nxt;
                        byte_cnt_r <= {f_val[6:0], 1'b0}; // see RULE_06
                        rd_base_r  <= w_off; // see RULE_07
                        tx_idx_r   <= 9'h000;
                        if (kind_nxt == K_READ) begin
                            tx_len_r <= `MBS_RD_DATA_IDX + {1'b0, f_val[6:0], 1'b0};
                        end else if (kind_nxt == K_EXC) begin
                            tx_len_r <= `MBS_EXC_TX_BYTES;
                        end else begin
                            tx_len_r <= `MBS_REQ_BYTES;
                        end
                        if (do_coil) begin
                            COIL_STATE[f_addr[5:0]] <= (f_val == `MBS_COIL_ON); // see RULE_03 RULE_13
                            FWD_VALID <= SLAVE_PRESENT[coil_slave]; // see RULE_09
                            FWD_COIL  <= 1'b1;
                            FWD_SLAVE <= coil_slave;
                            FWD_ADDR  <= f_addr;
                            FWD_DATA  <= {15'h0000, f_val == `MBS_COIL_ON};
                        end
                        if (do_word) begin
                            FWD_VALID <= SLAVE_PRESENT[word_slave]; // see RULE_09
                            FWD_COIL  <= 1'b0;
                            FWD_SLAVE <= word_slave;
                            FWD_ADDR  <= f_addr;
                            FWD_DATA  <= swapped; // see RULE_11
                        end
                        state_r <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (!TX_VALID || TX_READY) begin
                        if (tx_idx_r < tx_len_r) begin
                            TX_DATA  <= tx_byte;
                            TX_VALID <= 1'b1;
                            TX_LAST  <= (tx_idx_r == tx_len_r - 9'h001);
                            tx_idx_r <= tx_idx_r + 9'h001;
                        end else begin
                            TX_VALID <= 1'b0;
                            TX_LAST  <= 1'b0;
                            state_r  <= S_RECV;
                        end
                    end
                end
                default: begin
                    state_r <= S_RECV;
                end
            endcase
        end
    end

endmodule // mbs_server

`default_nettype wire

//--- verification/mbs_server_props.sv
// Port-level assertions for the mapping server.
`timescale 1ns/1ps
`default_nettype none
`include "mbs_defines.vh"
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module mbs_server_props (
    input wire        CLK_SYS,
    input wire        SRST,
    input wire [7:0]  UNIT_ADDR,
    input wire        RX_VALID,
    input wire        RX_LAST,
    input wire        RX_READY,
    input wire [7:0]  TX_DATA,
    input wire        TX_VALID,
    input wire        TX_LAST,
    input wire        TX_READY,
    input wire [15:0] SLAVE_PRESENT,
    input wire        FWD_VALID,
    input wire        FWD_COIL,
    input wire [3:0]  FWD_SLAVE,
    input wire [15:0] FWD_ADDR,
    input wire [15:0] FWD_DATA,
    input wire [63:0] COIL_STATE
);
    wire [15:0] widx = FWD_ADDR - `MBS_WORD_BASE;
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);
    property p_rdy_tx; TX_VALID |-> !RX_READY; endproperty
    a_rdy_tx: assert property (p_rdy_tx) else $error("reply overlaps request");
    property p_last_rdy; RX_VALID && RX_READY && RX_LAST |=> !RX_READY; endproperty
    a_last_rdy: assert property (p_last_rdy) else $error("ready after last");
    property p_tx_hold;
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("reply byte not held");
    property p_tx_end; TX_VALID && TX_READY && TX_LAST |=> !TX_VALID; endproperty
    a_tx_end: assert property (p_tx_end) else $error("reply runs past last");
    property p_coil_chg; !$stable(COIL_STATE) |-> !RX_READY; endproperty
    a_coil_chg: assert property (p_coil_chg) else $error("coil change outside exec");
    property p_fwd_one; FWD_VALID |=> !FWD_VALID [*8]; endproperty
    a_fwd_one: assert property (p_fwd_one) else $error("forward pulse too long");
    property p_fwd_hold;
        RX_READY || TX_VALID |-> $stable(FWD_ADDR) && $stable(FWD_DATA) && $stable(FWD_SLAVE)
            && $stable(FWD_COIL);
    endproperty
    a_fwd_hold: assert property (p_fwd_hold) else $error("forward fields moved");
    property p_fwd_coil;
        FWD_VALID && FWD_COIL |-> FWD_ADDR >= `MBS_COIL_BASE && FWD_ADDR <= `MBS_COIL_LAST
            && FWD_SLAVE == FWD_ADDR[5:2] && SLAVE_PRESENT[FWD_SLAVE]
            && FWD_DATA[15:1] == 15'h0000 && COIL_STATE[FWD_ADDR[5:0]] == FWD_DATA[0];
    endproperty
    a_fwd_coil: assert property (p_fwd_coil) else $error("bad coil forward");
    property p_fwd_word;
        FWD_VALID && !FWD_COIL |-> FWD_ADDR >= `MBS_WORD_BASE && FWD_ADDR <= `MBS_WORD_LAST
            && FWD_SLAVE == widx[8:5] && SLAVE_PRESENT[FWD_SLAVE];
    endproperty
    a_fwd_word: assert property (p_fwd_word) else $error("bad word forward");
    property p_unit_bad;
        UNIT_ADDR == 8'h00 || UNIT_ADDR > `MBS_UNIT_MAX |-> !TX_VALID;
    endproperty
    a_unit_bad: assert property (p_unit_bad) else $error("reply with bad unit");
endmodule // mbs_server_props

bind mbs_server mbs_server_props u_props (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .UNIT_ADDR(UNIT_ADDR), .RX_VALID(RX_VALID),
    .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
    .TX_LAST(TX_LAST), .TX_READY(TX_READY), .SLAVE_PRESENT(SLAVE_PRESENT),
    .FWD_VALID(FWD_VALID), .FWD_COIL(FWD_COIL), .FWD_SLAVE(FWD_SLAVE),
    .FWD_ADDR(FWD_ADDR), .FWD_DATA(FWD_DATA), .COIL_STATE(COIL_STATE)
);
`default_nettype wire

//--- verification/mbs_master_model.sv
// Remote request master: sends request frames and collects replies.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Request master
// ------------------------------------------------------------
module mbs_master_model (
    input  wire       clk,
    output reg  [7:0] rx_data = 8'h00,
    output reg        rx_valid = 1'b0,
    output reg        rx_last = 1'b0,
    input  wire       rx_ready,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    input  wire       tx_last,
    output reg        tx_ready = 1'b1
);
    reg [7:0] rsp [0:31];
    integer   rn = 0;
    integer   ln = 0;
    reg       slow = 1'b0;
    reg       tmo = 1'b0;
    // Slow mode stalls every other cycle so each reply byte must be held.
    always @(posedge clk) begin
        #1 tx_ready = slow ? ~tx_ready : 1'b1;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            rsp[rn[4:0]] = tx_data;
            if (tx_last) ln = rn + 1;
            rn = rn + 1;
        end
    end
    task send(input [95:0] f, input integer n);
        integer i;
        integer w;
        begin
            @(posedge clk);
            #1;
            for (i = 0; i < n; i = i + 1) begin
                rx_data = f[95-8*i -: 8];
                rx_valid = 1'b1;
                rx_last = (i == n - 1);
                w = 0;
                @(posedge clk);
                while (!rx_ready && w < 100) begin
                    w = w + 1;
                    @(posedge clk);
                end
                tmo = tmo | (w >= 100);
                #1;
            end
            rx_valid = 1'b0;
            rx_last = 1'b0;
            // An idle line must not keep showing the last byte.
            rx_data = ~rx_data;
        end
    endtask
endmodule // mbs_master_model
`default_nettype wire

//--- verification/tb_mbs_server.sv
// Self-checking testbench for the mapping server.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module tb_mbs_server;
    reg         clk = 1'b0;
    reg         srst = 1'b1;
    reg  [7:0]  unit = 8'h01;
    reg  [15:0] pres = 16'h7FFF;
    reg  [15:0] swp = 16'h0001;
    wire [7:0]  rxd, txd;
    wire        rxv, rxl, rxr, txv, txl, txr, fv, fc;
    wire [3:0]  fs;
    wire [15:0] fa, fd;
    wire [63:0] coil;
    integer     fails = 0;
    integer     total_checks = 0;
    integer     nfwd = 0;
    localparam [287:0] EXC_TAB = {48'h04_0000_0000_01, 48'h06_501D_0001_02,
        48'h05_0080_FF00_02, 48'h05_0040_1234_03, 48'h03_4E20_0000_03, 48'h03_501C_0002_02};
    always #10 clk = ~clk;
    always @(posedge clk) if (fv === 1'b1) nfwd = nfwd + 1;
    mbs_server dut (
        .CLK_SYS(clk), .SRST(srst), .UNIT_ADDR(unit), .RX_DATA(rxd), .RX_VALID(rxv),
        .RX_LAST(rxl), .RX_READY(rxr), .TX_DATA(txd), .TX_VALID(txv), .TX_LAST(txl),
        .TX_READY(txr), .SLAVE_PRESENT(pres), .SLAVE_SWAP(swp), .FWD_VALID(fv),
        .FWD_COIL(fc), .FWD_SLAVE(fs), .FWD_ADDR(fa), .FWD_DATA(fd), .COIL_STATE(coil));
    mbs_master_model m (
        .clk(clk), .rx_data(rxd), .rx_valid(rxv), .rx_last(rxl), .rx_ready(rxr),
        .tx_data(txd), .tx_valid(txv), .tx_last(txl), .tx_ready(txr));
    task final_report;
        begin
            $display("checks %0d mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input [63:0] got, input [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Sends a frame, waits for the server to reopen, compares the reply; n of 12 is an echo.
    task run(input [95:0] f, input integer nb, input [255:0] e, input integer n);
        integer i;
        begin
            m.send(f, nb);
            if (n == 12) e = {f, 160'h0};
            i = 0;
            while (rxr !== 1'b1 && i < 200) begin
                @(posedge clk);
                #1;
                i = i + 1;
            end
            if (i >= 200 || m.tmo) begin
                fails = fails + 1;
                $display("mismatch at %0t: no completion", $time);
                final_report;
            end
            chk(m.rn, n);
            chk(m.ln, n);
            for (i = 0; i < n; i = i + 1) chk(m.rsp[i], e[255-8*i -: 8]);
            m.rn = 0;
            m.ln = 0;
        end
    endtask
    task t_coil;
        begin
            run(96'h0001_0000_0006_01_05_0040_FF00, 12, 0, 12);
            chk(coil[0], 1'b1);
            chk(nfwd, 1);
            chk({fc, fs, fa, fd}, {1'b1, 4'h0, 16'h0040, 16'h0001});
            run(96'h0002_0000_0006_01_05_007F_FF00, 12, 0, 12);
            chk(coil[63], 1'b1);
            run(96'h0003_0000_0006_01_05_007F_0000, 12, 0, 12);
            chk({coil[63], coil[0], nfwd[3:0]}, 6'h11);
            $display("coil test done");
        end
    endtask
    task t_word;
        begin
            m.slow = 1'b1;
            run(96'h0004_0000_0006_01_06_4E20_0064, 12, 0, 12);
            chk({fc, fs, fa, fd}, {1'b0, 4'h0, 16'h4E20, 16'h6400});
            run(96'h0005_0000_0006_01_06_4E21_ABCD, 12, 0, 12);
            run(96'h0006_0000_0006_01_06_501C_1234, 12, 0, 12);
            chk({fc, fs, fa, fd}, {1'b0, 4'hF, 16'h501C, 16'h1234});
            chk(nfwd, 3);
            run(96'h0007_0000_0006_01_03_4E20_0002, 12,
                {104'h0007_0000_0007_01_03_04_0064_ABCD, 152'h0}, 13);
            run(96'h0008_0000_0006_01_03_501C_0001, 12,
                {88'h0008_0000_0005_01_03_02_1234, 168'h0}, 11);
            m.slow = 1'b0;
            $display("word test done");
        end
    endtask
    task t_exc;
        reg [47:0] t;
        integer    i;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                t = EXC_TAB[287-48*i -: 48];
                run({56'h0010_0000_0006_01, t[47:8]}, 12,
                    {56'h0010_0000_0003_01, t[47:40] | 8'h80, t[7:0], 184'h0}, 9);
            end
            run(96'h0011_0000_0006_01_0F_0040_0002, 12,
                {72'h0011_0000_0003_01_8F_01, 184'h0}, 9);
            chk(coil[0], 1'b1);
            $display("exception test done");
        end
    endtask
    task t_drop;
        begin
            run(96'h0020_0000_0006_02_05_0041_FF00, 12, 0, 0);
            run(96'h0021_0001_0006_01_05_0041_FF00, 12, 0, 0);
            run(96'h0022_0000_0005_01_05_0041_FF00, 12, 0, 0);
            run(96'h0023_0000_0006_01_05_0041_FF00, 7, 0, 0);
            unit = 8'h00;
            run(96'h0024_0000_0006_00_05_0041_FF00, 12, 0, 0);
            unit = 8'h01;
            chk({coil[1], nfwd[3:0]}, 5'h03);
            $display("drop test done");
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
        chk(coil, 64'h0);
        chk({txv, fv, rxr}, 3'h0);
        t_coil;
        t_word;
        t_exc;
        t_drop;
        final_report;
    end
endmodule // tb_mbs_server
`default_nettype wire
